// file: bench/hsb_asserts.sv
// checker: open-drain drive and wake-up timing on the two sleep/wake pins
`timescale 1ns/100ps
module hsb_asserts
    import hsb_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host sleep/wake pin
    input wire logic host_sw_dev_o,
    input wire logic host_sw_dev_oe,
    input wire logic host_sw_sys_o,
    input wire logic host_sw_sys_oe,
    input wire logic host_sleep_wake_pin,
    // peripheral sleep/wake pin
    input wire logic periph_sw_dev_o,
    input wire logic periph_sw_dev_oe,
    input wire logic periph_sw_sys_o,
    input wire logic periph_sw_sys_oe,
    input wire logic periph_sleep_wake_pin
);
    // ----------------------------------------
    // wake pulse length counters
    // ----------------------------------------
    logic [CNT_W-1:0] hcnt_r;
    logic [CNT_W-1:0] hcnt_nxt;
    logic [CNT_W-1:0] pcnt_r;
    logic [CNT_W-1:0] pcnt_nxt;

    // cycles the system end has pulled low so far; a plain repetition would be too long to unroll
    always_comb begin
        hcnt_nxt = (rst_i || !host_sw_sys_oe) ? '0 : hcnt_r + 1'b1;
        pcnt_nxt = (rst_i || !periph_sw_sys_oe) ? '0 : pcnt_r + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        hcnt_r <= hcnt_nxt;
        pcnt_r <= pcnt_nxt;
    end

    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_host_dev_od;
        host_sw_dev_oe |-> !host_sw_dev_o && !host_sleep_wake_pin;
    endproperty
    property p_per_dev_od;
        periph_sw_dev_oe |-> !periph_sw_dev_o && !periph_sleep_wake_pin;
    endproperty
    property p_host_sys_od;
        host_sw_sys_oe |-> !host_sw_sys_o && !host_sleep_wake_pin;
    endproperty
    property p_per_sys_od;
        periph_sw_sys_oe |-> !periph_sw_sys_o && !periph_sleep_wake_pin;
    endproperty
    property p_host_wake;
        (!host_sw_dev_oe && !host_sleep_wake_pin) [*5] |=> host_sw_dev_oe;
    endproperty
    property p_per_wake;
        (!periph_sw_dev_oe && !periph_sleep_wake_pin) [*5] |=> periph_sw_dev_oe;
    endproperty
    property p_host_pulse;
        $fell(host_sw_sys_oe) |-> hcnt_r == CNT_W'(WAKE_PULSE_CYC);
    endproperty
    property p_per_pulse;
        $fell(periph_sw_sys_oe) |-> pcnt_r == CNT_W'(WAKE_PULSE_CYC);
    endproperty
    property p_host_no_short;
        $rose(host_sw_dev_oe) |-> !$past(host_sleep_wake_pin, 1) && !$past(host_sleep_wake_pin, 5);
    endproperty

    a_host_dev_od: assert property (p_host_dev_od) else $error("host pin driven high by controller");
    a_per_dev_od: assert property (p_per_dev_od) else $error("periph pin driven high by controller");
    a_host_sys_od: assert property (p_host_sys_od) else $error("host pin driven high by system");
    a_per_sys_od: assert property (p_per_sys_od) else $error("periph pin driven high by system");
    a_host_wake: assert property (p_host_wake) else $error("host did not wake after low pulse");
    a_per_wake: assert property (p_per_wake) else $error("periph did not wake after low pulse");
    a_host_pulse: assert property (p_host_pulse) else $error("host wake pulse length wrong");
    a_per_pulse: assert property (p_per_pulse) else $error("periph wake pulse length wrong");
    a_host_no_short: assert property (p_host_no_short) else $error("host woke without a full low pulse");

    c_host_wake: cover property ($rose(host_sw_dev_oe));
    c_per_wake: cover property ($rose(periph_sw_dev_oe));
    c_host_pulse: cover property ($fell(host_sw_sys_oe));
endmodule

// file: bench/tb.sv
// testbench: both ends joined on one link, results scoreboarded at wishbone reads
`timescale 1ns/100ps
module tb;
    import hsb_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [1:0]  dreq_pol, dack_pol, irq_pol, irq_req, dma_req, susp_req;
    logic        sh_irq, sh_dma, pwr_on, ext_vbus;
    logic        cyc, stb, we, ack, irq;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat_w, dat_r, rnd;
    logic [1:0]  gnt, wake, susp, x_susp, x_gnt;
    logic        x_irq;
    logic [36:0] q[$];
    int          failures = 0;
    int          n_tests = 0;
    int          wakes = 0;
    int          seed = 4230;
    int          k;

    hsb_if lnk();
    hsb_dev hsb_dev_inst (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .dreq_pol_i(dreq_pol), .dack_pol_i(dack_pol),
        .irq_pol_i(irq_pol), .shared_irq_select_i(sh_irq), .shared_dma_select_i(sh_dma), .irq_req_i(irq_req),
        .dma_req_i(dma_req), .suspend_req_i(susp_req), .dma_grant_o(gnt), .wake_o(wake), .suspended_o(susp),
        .port_power_on_i(pwr_on), .ext_vbus_i(ext_vbus));
    hsb_sys hsb_sys_inst (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq));
    hsb_asserts hsb_asserts_inst (.clk_i(clk_i), .rst_i(rst_i),
        .host_sw_dev_o(lnk.host_sw_dev_o), .host_sw_dev_oe(lnk.host_sw_dev_oe),
        .host_sw_sys_o(lnk.host_sw_sys_o), .host_sw_sys_oe(lnk.host_sw_sys_oe),
        .host_sleep_wake_pin(lnk.host_sleep_wake_pin),
        .periph_sw_dev_o(lnk.periph_sw_dev_o), .periph_sw_dev_oe(lnk.periph_sw_dev_oe),
        .periph_sw_sys_o(lnk.periph_sw_sys_o), .periph_sw_sys_oe(lnk.periph_sw_sys_oe),
        .periph_sleep_wake_pin(lnk.periph_sleep_wake_pin));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // checking and bus tasks
    // ----------------------------------------
    task automatic chk(input logic [36:0] seen, input logic [36:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // one classic cycle; the idle cycle after it keeps two requests from merging
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dw);
        int i;
        {cyc, stb, we, adr, dat_w, sel} <= {2'b11, w, a, dw, 4'hF};
        for (i = 0; i < 20; i++) begin
            @(posedge clk_i);
            if (ack === 1'b1) begin
                break;
            end
        end
        {cyc, stb, we} <= 3'b000;
        @(posedge clk_i);
        if (i == 20) begin
            failures++;
            $display("unexpected at %0t: no bus answer", $time);
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    // the note carries the system irq and the controller suspend and grant levels expected at the same moment
    task automatic rd(input logic [7:0] a, input logic [31:0] d);
        q.push_back({x_irq, x_susp, x_gnt, d});
        bus(1'b0, a, 32'h0);
    endtask

    always @(posedge clk_i) begin
        wakes += (wake[0] === 1'b1) + (wake[1] === 1'b1);
        if (ack === 1'b1 && we === 1'b0) begin
            chk({irq, susp, gnt, dat_r}, q.size() > 0 ? q.pop_front() : 37'hX);
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {dreq_pol, dack_pol, irq_pol} = 6'h3F;
        {irq_req, dma_req, susp_req, sh_irq, sh_dma, pwr_on, ext_vbus} = '0;
        {cyc, stb, we, adr, sel, dat_w} = '0;
        {x_irq, x_susp, x_gnt} = '0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(ADDR_CTRL, 32'h7F);
        rd(ADDR_MASK, 32'h0);
        rd(ADDR_STAT, 32'h0);
        rd(ADDR_PINS, 32'h40);
        wr(8'h20, 32'hFFFFFFFF);
        rd(8'h20, 32'h0);
        rd(ADDR_CMD, 32'h0);
        // random polarities, requests and power inputs
        for (k = 0; k < 8; k++) begin
            rnd = $random(seed);
            wr(ADDR_CTRL, {25'h0, 1'b1, rnd[5:0]});
            {irq_pol, dack_pol, dreq_pol} <= rnd[5:0];
            {irq_req, dma_req, pwr_on, ext_vbus} <= rnd[11:6];
            x_gnt = rnd[9:8];
            repeat (6) @(posedge clk_i);
            rd(ADDR_PINS, {25'h0, ~(rnd[7] & rnd[6]), 2'b00, ~(rnd[11:10] ^ rnd[5:4]), ~(rnd[9:8] ^ rnd[1:0])});
        end
        wr(ADDR_CTRL, 32'h7F);
        {irq_pol, dack_pol, dreq_pol} <= 6'h3F;
        {irq_req, dma_req, pwr_on, ext_vbus} <= 6'h00;
        x_gnt = 2'b00;
        repeat (6) @(posedge clk_i);
        // shared dma: both channels on host pins, host wins a tie
        sh_dma <= 1'b1;
        dma_req <= 2'b10;
        x_gnt = 2'b10;
        repeat (6) @(posedge clk_i);
        rd(ADDR_PINS, 32'h41);
        dma_req <= 2'b11;
        x_gnt = 2'b01;
        repeat (6) @(posedge clk_i);
        rd(ADDR_PINS, 32'h41);
        {sh_dma, dma_req} <= 3'b000;
        x_gnt = 2'b00;
        repeat (6) @(posedge clk_i);
        wr(ADDR_STAT, 32'h3F);
        rd(ADDR_STAT, 32'h0);
        // interrupts: raise, merge, clear, mask
        wr(ADDR_MASK, 32'h02);
        irq_req <= 2'b10;
        repeat (4) @(posedge clk_i);
        x_irq = 1'b1;
        rd(ADDR_PINS, 32'h48);
        rd(ADDR_STAT, 32'h02);
        sh_irq <= 1'b1;
        repeat (4) @(posedge clk_i);
        rd(ADDR_PINS, 32'h44);
        rd(ADDR_STAT, 32'h03);
        {sh_irq, irq_req} <= 3'b000;
        repeat (4) @(posedge clk_i);
        wr(ADDR_STAT, 32'h01);
        rd(ADDR_STAT, 32'h02);
        wr(ADDR_MASK, 32'h01);
        x_irq = 1'b0;
        rd(ADDR_STAT, 32'h02);
        wr(ADDR_STAT, 32'h02);
        rd(ADDR_STAT, 32'h0);
        // suspend both, then wake each with a pulse from the system end
        wr(ADDR_MASK, 32'h30);
        susp_req <= 2'b11;
        @(posedge clk_i);
        susp_req <= 2'b00;
        repeat (4) @(posedge clk_i);
        {x_susp, x_irq} = 3'b111;
        rd(ADDR_PINS, 32'h70);
        rd(ADDR_STAT, 32'h30);
        wr(ADDR_CMD, 32'h01);
        repeat (8) @(posedge clk_i);
        x_susp = 2'b10;
        rd(ADDR_PINS, 32'h60);
        repeat (50) @(posedge clk_i);
        rd(ADDR_PINS, 32'h60);
        wr(ADDR_CMD, 32'h02);
        repeat (60) @(posedge clk_i);
        x_susp = 2'b00;
        rd(ADDR_PINS, 32'h40);
        wr(ADDR_STAT, 32'h30);
        x_irq = 1'b0;
        rd(ADDR_STAT, 32'h0);
        chk(37'(wakes), 37'h2);
        test_done();
    end
endmodule

// file: core/hsb_dev.sv
// module: controller-side sideband pin logic (dma, interrupts, sleep/wake, power)
`timescale 1ns/100ps
module hsb_dev (
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,

    // link to the system
    hsb_if.dev                          lnk,

    // hardware configuration bits, index hsb_pkg::CH_HOST / CH_PERIPH
    input  wire logic [hsb_pkg::NCH-1:0] dreq_pol_i,
    input  wire logic [hsb_pkg::NCH-1:0] dack_pol_i,
    input  wire logic [hsb_pkg::NCH-1:0] irq_pol_i,
    input  wire logic                   shared_irq_select_i,
    input  wire logic                   shared_dma_select_i,

    // controller requests and events
    input  wire logic [hsb_pkg::NCH-1:0] irq_req_i,
    input  wire logic [hsb_pkg::NCH-1:0] dma_req_i,
    input  wire logic [hsb_pkg::NCH-1:0] suspend_req_i,
    output logic      [hsb_pkg::NCH-1:0] dma_grant_o,
    output logic      [hsb_pkg::NCH-1:0] wake_o,
    output logic      [hsb_pkg::NCH-1:0] suspended_o,

    // port 1 power
    input  wire logic                   port_power_on_i,
    input  wire logic                   ext_vbus_i
);
    import hsb_pkg::*;

    // ---------------------------------------------------------------
    // dma, interrupt and power pins
    // ---------------------------------------------------------------
    logic           hreq_r, hreq_nxt;
    logic           preq_r, preq_nxt;
    logic           hirq_r, hirq_nxt;
    logic           pirq_r, pirq_nxt;
    logic           pwr_n_r, pwr_n_nxt;
    logic [NCH-1:0] gnt_r, gnt_nxt;

    // decoded grants and merged host activity
    logic           h_gnt;
    logic           p_gnt;
    logic           h_req_act;
    logic           h_irq_act;

    always_comb begin
        h_gnt = (lnk.host_dma_grant == dack_pol_i[CH_HOST]);
        p_gnt = (lnk.periph_dma_grant == dack_pol_i[CH_PERIPH]);
        if (shared_dma_select_i) begin
            // one grant pin serves both channels; host wins a tie
            h_req_act              = dma_req_i[CH_HOST] | dma_req_i[CH_PERIPH];
            gnt_nxt[CH_HOST]       = h_gnt & dma_req_i[CH_HOST];
            gnt_nxt[CH_PERIPH]     = h_gnt & dma_req_i[CH_PERIPH] & ~dma_req_i[CH_HOST];
            preq_nxt               = ~dreq_pol_i[CH_PERIPH];
        end else begin
            h_req_act              = dma_req_i[CH_HOST];
            gnt_nxt[CH_HOST]       = h_gnt;
            gnt_nxt[CH_PERIPH]     = p_gnt;
            preq_nxt               = dma_req_i[CH_PERIPH] ? dreq_pol_i[CH_PERIPH]
                                                          : ~dreq_pol_i[CH_PERIPH];
        end

        // host pin carries the merged request in shared mode
        hreq_nxt = h_req_act ? dreq_pol_i[CH_HOST] : ~dreq_pol_i[CH_HOST];

        // shared mode uses the host polarity for the merged line
        if (shared_irq_select_i) begin
            h_irq_act = irq_req_i[CH_HOST] | irq_req_i[CH_PERIPH];
            pirq_nxt  = ~irq_pol_i[CH_PERIPH];
        end else begin
            h_irq_act = irq_req_i[CH_HOST];
            pirq_nxt  = irq_req_i[CH_PERIPH] ? irq_pol_i[CH_PERIPH] : ~irq_pol_i[CH_PERIPH];
        end
        hirq_nxt  = h_irq_act ? irq_pol_i[CH_HOST] : ~irq_pol_i[CH_HOST];

        // the switch only matters with an external vbus source; otherwise keep it off
        pwr_n_nxt = ~(port_power_on_i & ext_vbus_i);
    end

    always_ff @(posedge clk_i) begin
        // request and interrupt pins sit low in reset whatever the polarity, the power switch pin high (off); idle level follows one edge later
        if (rst_i) begin
            hreq_r  <= 1'b0;
            preq_r  <= 1'b0;
            hirq_r  <= 1'b0;
            pirq_r  <= 1'b0;
            pwr_n_r <= 1'b1;
            gnt_r   <= '0;
        end else begin
            hreq_r  <= hreq_nxt;
            preq_r  <= preq_nxt;
            hirq_r  <= hirq_nxt;
            pirq_r  <= pirq_nxt;
            pwr_n_r <= pwr_n_nxt;
            gnt_r   <= gnt_nxt;
        end
    end

    // every pin comes straight from a flop
    assign lnk.host_dma_request     = hreq_r;
    assign lnk.periph_dma_request   = preq_r;
    assign lnk.host_irq_out         = hirq_r;
    assign lnk.periph_irq_out       = pirq_r;
    assign lnk.port1_power_switch_n = pwr_n_r;
    assign dma_grant_o              = gnt_r;

    // ---------------------------------------------------------------
    // sleep/wake per controller
    // ---------------------------------------------------------------
    logic [NCH-1:0] sw_pin;
    logic [NCH-1:0] sw_oe;

    // resolved pin levels as seen by this end
    assign sw_pin[CH_HOST]   = lnk.host_sleep_wake_pin;
    assign sw_pin[CH_PERIPH] = lnk.periph_sleep_wake_pin;

    // only ever pull low; the pull-up gives the high level
    assign lnk.host_sw_dev_o    = 1'b0;
    assign lnk.periph_sw_dev_o  = 1'b0;

    assign lnk.host_sw_dev_oe   = sw_oe[CH_HOST];
    assign lnk.periph_sw_dev_oe = sw_oe[CH_PERIPH];

    genvar c;

    generate
        for (c = 0; c < NCH; c++) begin : g_slp
            // one sleep machine per controller
            hsb_slp_t          st_r, st_nxt;
            logic [CNT_W-1:0]  low_r, low_nxt;
            logic              oe_r, oe_nxt;
            logic              wk_r, wk_nxt;
            logic              sp_r, sp_nxt;

            always_comb begin
                st_nxt  = st_r;
                low_nxt = '0;
                wk_nxt  = 1'b0;

                unique case (st_r)
                    SLP_AWAKE: begin
                        if (suspend_req_i[c]) begin
                            st_nxt = SLP_SUSP;
                        end
                    end

                    SLP_SUSP: begin
                        // a short glitch low is not a wake request
                        if (!sw_pin[c]) begin
                            low_nxt = low_r + CNT_W'(1);
                            if (low_r == CNT_W'(WAKE_MIN_CYC - 1)) begin
                                st_nxt  = SLP_AWAKE;
                                wk_nxt  = 1'b1;
                                low_nxt = '0;
                            end
                        end
                    end

                    default: begin
                        st_nxt = SLP_AWAKE;
                    end
                endcase

                // released only while suspended, pulled low otherwise
                oe_nxt = (st_nxt != SLP_SUSP);
                sp_nxt = (st_nxt == SLP_SUSP);
            end

            always_ff @(posedge clk_i) begin
                // reset state is awake with the pin held low
                if (rst_i) begin
                    st_r  <= SLP_AWAKE;
                    low_r <= '0;
                    oe_r  <= 1'b1;
                    wk_r  <= 1'b0;
                    sp_r  <= 1'b0;
                end else begin
                    st_r  <= st_nxt;
                    low_r <= low_nxt;
                    oe_r  <= oe_nxt;
                    wk_r  <= wk_nxt;
                    sp_r  <= sp_nxt;
                end
            end

            // registered pin drive and status for the controller
            assign sw_oe[c]       = oe_r;
            assign wake_o[c]      = wk_r;
            assign suspended_o[c] = sp_r;
        end
    endgenerate
endmodule

// file: core/hsb_if.sv
// interface: sideband pins between the dual-role controller and the system
`timescale 1ns/100ps
interface hsb_if;
    logic host_dma_request;
    logic periph_dma_request;
    logic host_dma_grant;
    logic periph_dma_grant;
    logic host_irq_out;
    logic periph_irq_out;
    logic port1_power_switch_n;
    // open-drain sleep/wake pins: each end only pulls low, a pull-up does the rest
    logic host_sw_dev_o;
    logic host_sw_dev_oe;
    logic host_sw_sys_o;
    logic host_sw_sys_oe;
    logic periph_sw_dev_o;
    logic periph_sw_dev_oe;
    logic periph_sw_sys_o;
    logic periph_sw_sys_oe;
    logic host_sleep_wake_pin;
    logic periph_sleep_wake_pin;

    assign host_sleep_wake_pin   = !((host_sw_dev_oe && !host_sw_dev_o) ||
                                     (host_sw_sys_oe && !host_sw_sys_o));
    assign periph_sleep_wake_pin = !((periph_sw_dev_oe && !periph_sw_dev_o) ||
                                     (periph_sw_sys_oe && !periph_sw_sys_o));

    modport dev (
        output host_dma_request, periph_dma_request, host_irq_out, periph_irq_out,
        output port1_power_switch_n,
        output host_sw_dev_o, host_sw_dev_oe, periph_sw_dev_o, periph_sw_dev_oe,
        input  host_dma_grant, periph_dma_grant,
        input  host_sleep_wake_pin, periph_sleep_wake_pin
    );
    modport sys (
        input  host_dma_request, periph_dma_request, host_irq_out, periph_irq_out,
        input  port1_power_switch_n,
        output host_sw_sys_o, host_sw_sys_oe, periph_sw_sys_o, periph_sw_sys_oe,
        output host_dma_grant, periph_dma_grant,
        input  host_sleep_wake_pin, periph_sleep_wake_pin
    );
endinterface

// file: core/hsb_pkg.sv
// package: constants and types shared by both ends of the sideband link
package hsb_pkg;
    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 20;
    localparam int WAKE_PULSE_NS  = 1000;
    localparam int WAKE_MIN_NS    = 100;
    // both are least times, so round up
    localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_MIN_CYC   = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W          = 6;
    // ---------------------------------------------------------------
    // channels
    // ---------------------------------------------------------------
    localparam int CH_HOST   = 0;
    localparam int CH_PERIPH = 1;
    localparam int NCH       = 2;
    // ---------------------------------------------------------------
    // wishbone register map of the system end
    // ---------------------------------------------------------------
    localparam int         ADDR_W    = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_CMD  = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_MASK = 8'h0C;
    localparam logic [7:0] ADDR_PINS = 8'h10;
    // control fields: polarity bits are 1 for active high
    localparam int         CTL_DREQ_POL = 0;
    localparam int         CTL_DACK_POL = 2;
    localparam int         CTL_IRQ_POL  = 4;
    localparam int         CTL_AUTO_GNT = 6;
    localparam int         CTL_W        = 7;
    localparam logic [6:0] CTL_RST      = 7'h7F;
    // command fields (write-only, self clearing)
    localparam int         CMD_WAKE     = 0;
    // status / mask fields
    localparam int         ST_IRQ       = 0;
    localparam int         ST_DREQ      = 2;
    localparam int         ST_SUSP      = 4;
    localparam int         ST_W         = 6;
    localparam logic [5:0] MASK_RST     = 6'h00;
    // live pin image fields
    localparam int         PIN_DREQ     = 0;
    localparam int         PIN_IRQ      = 2;
    localparam int         PIN_SW       = 4;
    localparam int         PIN_PWR_N    = 6;
    localparam int         PIN_W        = 7;
    // ---------------------------------------------------------------
    // sleep state of one controller
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        SLP_AWAKE = 2'b01,
        SLP_SUSP  = 2'b10
    } hsb_slp_t;
endpackage

// file: core/hsb_sys.sv
// module: system-side end (dma grant, interrupt capture, wake pulses) with a wishbone slave
`timescale 1ns/100ps
module hsb_sys (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // link to the controller
    hsb_if.sys                             lnk,
    // wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [hsb_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic      [31:0]               wb_dat_o,
    output logic                           wb_ack_o,
    // interrupt
    output logic                           irq_o
);
    import hsb_pkg::*;

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [CTL_W-1:0] ctl_r, ctl_nxt;
    logic [ST_W-1:0]  st_r, st_nxt;
    logic [ST_W-1:0]  msk_r, msk_nxt;
    logic [31:0]      dat_r, dat_nxt;
    logic             ack_r, ack_nxt;
    logic             irq_r, irq_nxt;
    logic [NCH-1:0]   gnt_r, gnt_nxt;
    logic [NCH-1:0]   req, irq, sw;
    logic [ST_W-1:0]  ev;
    logic [PIN_W-1:0] pins;
    logic             wr;
    logic [NCH-1:0]   wake_cmd;

    // ---------------------------------------------------------------
    // link decode
    // ---------------------------------------------------------------
    assign req  = {lnk.periph_dma_request, lnk.host_dma_request} ~^ ctl_r[CTL_DREQ_POL +: NCH];
    assign irq  = {lnk.periph_irq_out, lnk.host_irq_out} ~^ ctl_r[CTL_IRQ_POL +: NCH];
    assign sw   = {lnk.periph_sleep_wake_pin, lnk.host_sleep_wake_pin};
    assign ev   = {sw & ~wake_cmd, req, irq};
    assign pins = {lnk.port1_power_switch_n, sw,
                   lnk.periph_irq_out, lnk.host_irq_out,
                   lnk.periph_dma_request, lnk.host_dma_request};

    // ---------------------------------------------------------------
    // bus slave, status and grants
    // ---------------------------------------------------------------
    always_comb begin
        ack_nxt  = wb_cyc_i & wb_stb_i & ~ack_r;
        wr       = ack_nxt & wb_we_i & wb_sel_i[0];
        ctl_nxt  = ctl_r;
        msk_nxt  = msk_r;
        wake_cmd = '0;
        dat_nxt  = 32'h0000_0000;
        // write one clears; a new event in the same cycle wins
        st_nxt   = st_r;
        if (wr && wb_adr_i == ADDR_STAT) begin
            st_nxt = st_r & ~wb_dat_i[ST_W-1:0];
        end
        st_nxt = st_nxt | ev;
        if (wr) begin
            unique case (wb_adr_i)
                ADDR_CTRL: ctl_nxt  = wb_dat_i[CTL_W-1:0];
                ADDR_MASK: msk_nxt  = wb_dat_i[ST_W-1:0];
                ADDR_CMD:  wake_cmd = wb_dat_i[CMD_WAKE +: NCH];
                default:   ctl_nxt  = ctl_r;
            endcase
        end
        if (ack_nxt && !wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_CTRL: dat_nxt = {{(32-CTL_W){1'b0}}, ctl_r};
                ADDR_STAT: dat_nxt = {{(32-ST_W){1'b0}}, st_r};
                ADDR_MASK: dat_nxt = {{(32-ST_W){1'b0}}, msk_r};
                ADDR_PINS: dat_nxt = {{(32-PIN_W){1'b0}}, pins};
                default:   dat_nxt = 32'h0000_0000;
            endcase
        end
        irq_nxt = |(st_nxt & msk_nxt);
        // grant follows a live request while automatic granting is on
        gnt_nxt = (req & {NCH{ctl_r[CTL_AUTO_GNT]}}) ~^ ctl_r[CTL_DACK_POL +: NCH];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_r <= CTL_RST;
            msk_r <= MASK_RST;
            st_r  <= '0;
            dat_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            irq_r <= 1'b0;
            gnt_r <= '0;
        end else begin
            ctl_r <= ctl_nxt;
            msk_r <= msk_nxt;
            st_r  <= st_nxt;
            dat_r <= dat_nxt;
            ack_r <= ack_nxt;
            irq_r <= irq_nxt;
            gnt_r <= gnt_nxt;
        end
    end

    assign wb_dat_o             = dat_r;
    assign wb_ack_o             = ack_r;
    assign irq_o                = irq_r;
    assign lnk.host_dma_grant   = gnt_r[CH_HOST];
    assign lnk.periph_dma_grant = gnt_r[CH_PERIPH];

    // ---------------------------------------------------------------
    // wake pulse generators
    // ---------------------------------------------------------------
    logic [NCH-1:0] pull;
    assign lnk.host_sw_sys_o    = 1'b0;
    assign lnk.periph_sw_sys_o  = 1'b0;
    assign lnk.host_sw_sys_oe   = pull[CH_HOST];
    assign lnk.periph_sw_sys_oe = pull[CH_PERIPH];

    genvar c;
    generate
        for (c = 0; c < NCH; c++) begin : g_wk
            logic [CNT_W-1:0] cnt_r, cnt_nxt;
            logic             pl_r, pl_nxt;
            always_comb begin
                cnt_nxt = cnt_r;
                if (wake_cmd[c] && cnt_r == '0) begin
                    cnt_nxt = CNT_W'(WAKE_PULSE_CYC);
                end else if (cnt_r != '0) begin
                    cnt_nxt = cnt_r - CNT_W'(1);
                end
                pl_nxt = (cnt_nxt != '0);
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cnt_r <= '0;
                    pl_r  <= 1'b0;
                end else begin
                    cnt_r <= cnt_nxt;
                    pl_r  <= pl_nxt;
                end
            end
            assign pull[c] = pl_r;
        end
    endgenerate
endmodule
